/* File: design/step_pkg.sv */
package step_pkg;

  localparam int          NUM_CH         = 2;
  localparam int          PARAM_W        = 32;
  localparam int          ADDR_W         = 8;
  // register map, per channel block of 0x20 bytes
  localparam logic [7:0]  CH_STRIDE      = 8'h20;
  localparam logic [7:0]  OFF_START_RATE = 8'h00;
  localparam logic [7:0]  OFF_RUN_RATE   = 8'h04;
  localparam logic [7:0]  OFF_ACCEL_CNT  = 8'h08;
  localparam logic [7:0]  OFF_RUN_CNT    = 8'h0C;
  localparam logic [7:0]  OFF_DECEL_CNT  = 8'h10;
  localparam logic [7:0]  OFF_CONTROL    = 8'h14;
  localparam logic [7:0]  OFF_STATUS     = 8'h18;
  localparam logic [7:0]  OFF_GLOBAL     = 8'h40;
  // control fields
  localparam int          CTL_MOVE_BIT   = 0;
  localparam int          CTL_PWM_BIT    = 1;
  // status fields
  localparam int          STS_IDLE_BIT   = 0;
  localparam int          STS_FAULT_BIT  = 1;
  localparam int          STS_BUSY_BIT   = 2;
  localparam int          STS_PIN_BIT    = 3;
  // global fields
  localparam int          GLB_STOP_BIT   = 0;
  // timebase and pwm scale
  localparam longint      CLK_HZ         = 100_000_000;
  localparam longint      TIMEBASE_HZ    = 10_000_000;
  localparam logic [7:0]  TB_DIV         = 8'(CLK_HZ / TIMEBASE_HZ);
  localparam logic [31:0] DUTY_FULL      = 32'h0000_7D00;
  localparam logic [31:0] ZERO32         = 32'h0000_0000;
  localparam logic [31:0] ONE32          = 32'h0000_0001;

  typedef enum logic [1:0] {
    PH_ACCEL,
    PH_RUN,
    PH_DECEL
  } phase_t;

  typedef struct packed {
    logic [31:0] start_rate;
    logic [31:0] run_rate;
    logic [31:0] accel_cnt;
    logic [31:0] run_cnt;
    logic [31:0] decel_cnt;
  } motion_t;

endpackage : step_pkg

/* File: design/stepper_pulse_profile_generator.sv */
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module stepper_pulse_profile_generator #(
  parameter int NUM_CH = step_pkg::NUM_CH
) (
  input  wire logic                       core_clk_i,
  input  wire logic                       reset_n_i,
  input  wire logic [step_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [31:0]                wdata_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output logic      [31:0]                rdata_o,
  output logic      [NUM_CH-1:0]          step_o,
  output logic      [NUM_CH-1:0]          idle_complete_o,
  output logic      [NUM_CH-1:0]          fault_o
);

  function automatic logic [31:0] tb_div(input logic [31:0] hz);
    // integer division of timebase; leftover fraction is lost
    if (hz == step_pkg::ZERO32) begin
      tb_div = step_pkg::ONE32;
    end else begin
      tb_div = 32'(step_pkg::TIMEBASE_HZ / 64'(hz));
    end
  endfunction : tb_div

  function automatic logic [31:0] lerp_rate(input logic [31:0] lo,
                                            input logic [31:0] hi,
                                            input logic [31:0] idx,
                                            input logic [31:0] cnt);
    logic [63:0] prod;
    prod = 64'(hi - lo) * 64'(idx);
    lerp_rate = lo + 32'(prod / 64'(cnt - step_pkg::ONE32));
  endfunction : lerp_rate

  // 10 MHz timebase tick shared by all channels
  logic [7:0] tb_cnt_reg;
  logic       tick_reg;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tb_cnt_reg <= 8'h00;
      tick_reg   <= 1'b0;
    end else if (tb_cnt_reg == step_pkg::TB_DIV - 8'h01) begin
      tb_cnt_reg <= 8'h00;
      tick_reg   <= 1'b1;
    end else begin
      tb_cnt_reg <= tb_cnt_reg + 8'h01;
      tick_reg   <= 1'b0;
    end
  end

  // software registers
  step_pkg::motion_t  prm_reg     [NUM_CH];
  logic [NUM_CH-1:0]  move_reg;
  logic [NUM_CH-1:0]  pwm_mode_reg;
  logic               stop_reg;
  logic [7:0]         ch_base     [NUM_CH];

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      ch_base[c] = 8'(c * int'(step_pkg::CH_STRIDE));
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        prm_reg[c] <= '0;
      end
      move_reg     <= '0;
      pwm_mode_reg <= '0;
      stop_reg     <= 1'b0;
    end else if (wr_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (addr_i == ch_base[c] + step_pkg::OFF_START_RATE) begin
          prm_reg[c].start_rate <= wdata_i;
        end
        if (addr_i == ch_base[c] + step_pkg::OFF_RUN_RATE) begin
          prm_reg[c].run_rate <= wdata_i;
        end
        if (addr_i == ch_base[c] + step_pkg::OFF_ACCEL_CNT) begin
          prm_reg[c].accel_cnt <= wdata_i;
        end
        if (addr_i == ch_base[c] + step_pkg::OFF_RUN_CNT) begin
          prm_reg[c].run_cnt <= wdata_i;
        end
        if (addr_i == ch_base[c] + step_pkg::OFF_DECEL_CNT) begin
          prm_reg[c].decel_cnt <= wdata_i;
        end
        if (addr_i == ch_base[c] + step_pkg::OFF_CONTROL) begin
          move_reg[c]     <= wdata_i[step_pkg::CTL_MOVE_BIT];
          pwm_mode_reg[c] <= wdata_i[step_pkg::CTL_PWM_BIT];
        end
      end
      if (addr_i == step_pkg::OFF_GLOBAL) begin
        stop_reg <= wdata_i[step_pkg::GLB_STOP_BIT];
      end
    end
  end

  // per-channel sequencer state
  step_pkg::motion_t  lat_reg   [NUM_CH];
  step_pkg::phase_t   phase_reg [NUM_CH];
  logic [31:0]        idx_reg   [NUM_CH];
  logic [31:0]        div_reg   [NUM_CH];
  logic [31:0]        tcnt_reg  [NUM_CH];
  logic [NUM_CH-1:0]  busy_reg;
  logic [NUM_CH-1:0]  move_d_reg;
  logic [NUM_CH-1:0]  pin_reg;
  logic [NUM_CH-1:0]  fault_reg;
  logic [NUM_CH-1:0]  bad_prm;
  logic [NUM_CH-1:0]  start_evt;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      start_evt[c] = move_reg[c] && !move_d_reg[c];
      bad_prm[c] =
        (((prm_reg[c].accel_cnt != '0) || (prm_reg[c].decel_cnt != '0)) &&
         ((prm_reg[c].start_rate == '0) ||
          (prm_reg[c].start_rate > prm_reg[c].run_rate))) ||
        (prm_reg[c].accel_cnt == step_pkg::ONE32) ||
        (prm_reg[c].decel_cnt == step_pkg::ONE32) ||
        (prm_reg[c].run_rate == '0);
    end
  end

  // next rate after finishing a cycle, or phase entry
  function automatic logic [31:0] phase_rate(input step_pkg::motion_t m,
                                             input step_pkg::phase_t p,
                                             input logic [31:0] i);
    case (p)
      step_pkg::PH_ACCEL: phase_rate =
        lerp_rate(m.start_rate, m.run_rate, i, m.accel_cnt);
      step_pkg::PH_DECEL: phase_rate =
        m.run_rate - (lerp_rate(m.start_rate, m.run_rate, i, m.decel_cnt)
                      - m.start_rate);
      default: phase_rate = m.run_rate;
    endcase
  endfunction : phase_rate

  function automatic logic [31:0] phase_len(input step_pkg::motion_t m,
                                            input step_pkg::phase_t p);
    case (p)
      step_pkg::PH_ACCEL: phase_len = m.accel_cnt;
      step_pkg::PH_DECEL: phase_len = m.decel_cnt;
      default:            phase_len = m.run_cnt;
    endcase
  endfunction : phase_len

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    step_pkg::phase_t  ph_first;
    step_pkg::phase_t  ph_after;
    logic              ph_none;
    logic              after_none;
    logic              last_cyc;
    logic [31:0]       half;
    logic              wait_tick;

    // first phase with a nonzero count, in fixed order
    always_comb begin
      ph_none  = 1'b0;
      if (prm_reg[c].accel_cnt != '0) begin
        ph_first = step_pkg::PH_ACCEL;
      end else if (prm_reg[c].run_cnt != '0) begin
        ph_first = step_pkg::PH_RUN;
      end else if (prm_reg[c].decel_cnt != '0) begin
        ph_first = step_pkg::PH_DECEL;
      end else begin
        ph_first = step_pkg::PH_RUN;
        ph_none  = 1'b1;
      end
      after_none = 1'b0;
      if (phase_reg[c] == step_pkg::PH_ACCEL &&
          lat_reg[c].run_cnt != '0) begin
        ph_after = step_pkg::PH_RUN;
      end else if (phase_reg[c] != step_pkg::PH_DECEL &&
                   lat_reg[c].decel_cnt != '0) begin
        ph_after = step_pkg::PH_DECEL;
      end else begin
        ph_after   = step_pkg::PH_RUN;
        after_none = 1'b1;
      end
      last_cyc = (idx_reg[c] + step_pkg::ONE32 ==
                  phase_len(lat_reg[c], phase_reg[c]));
      half = {1'b0, div_reg[c][31:1]};
      // all-ones count parks a fresh move until the shared tick
      wait_tick = (tcnt_reg[c] == '1);
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        lat_reg[c]    <= '0;
        phase_reg[c]  <= step_pkg::PH_RUN;
        idx_reg[c]    <= '0;
        div_reg[c]    <= step_pkg::ONE32;
        tcnt_reg[c]   <= '0;
        busy_reg[c]   <= 1'b0;
        move_d_reg[c] <= 1'b0;
        fault_reg[c]  <= 1'b0;
      end else begin
        move_d_reg[c] <= move_reg[c];
        if (busy_reg[c] && stop_reg) begin
          // stop ends the move quietly, no fault
          busy_reg[c] <= 1'b0;
          idx_reg[c]  <= '0;
          tcnt_reg[c] <= '0;
        end else if (busy_reg[c] && !move_reg[c]) begin
          busy_reg[c]  <= 1'b0;
          fault_reg[c] <= 1'b1;
        end else if (busy_reg[c]) begin
          if (tick_reg) begin
            if (wait_tick) begin
              tcnt_reg[c] <= '0;
            end else if (tcnt_reg[c] + step_pkg::ONE32 >= div_reg[c]) begin
              tcnt_reg[c] <= '0;
              if (!last_cyc) begin
                idx_reg[c] <= idx_reg[c] + step_pkg::ONE32;
                div_reg[c] <= tb_div(phase_rate(lat_reg[c], phase_reg[c],
                                   idx_reg[c] + step_pkg::ONE32));
              end else if (after_none) begin
                busy_reg[c] <= 1'b0;
              end else begin
                phase_reg[c] <= ph_after;
                idx_reg[c]   <= '0;
                div_reg[c]   <= tb_div(phase_rate(lat_reg[c], ph_after,
                                                  '0));
              end
            end else begin
              tcnt_reg[c] <= tcnt_reg[c] + step_pkg::ONE32;
            end
          end
        end else if (start_evt[c] && !pwm_mode_reg[c] && !stop_reg) begin
          if (bad_prm[c]) begin
            fault_reg[c] <= 1'b1;
          end else begin
            fault_reg[c] <= 1'b0;
            lat_reg[c]   <= prm_reg[c];
            phase_reg[c] <= ph_first;
            idx_reg[c]   <= '0;
            // wait for the shared tick so the first cycle is full length
            tcnt_reg[c]  <= '1;
            div_reg[c]   <= tb_div(phase_rate(prm_reg[c], ph_first,
                                              '0));
            busy_reg[c]  <= !ph_none;
          end
        end
      end
    end

    // pwm: period and high time counted in timebase ticks
    logic [31:0] pwm_cnt_reg;
    logic [31:0] pwm_per;
    logic [31:0] pwm_high;
    logic [63:0] pwm_prod;
    always_comb begin
      pwm_per  = tb_div(prm_reg[c].run_rate);
      pwm_prod = 64'(pwm_per) * 64'(prm_reg[c].start_rate);
      pwm_high = 32'(pwm_prod / 64'(step_pkg::DUTY_FULL));
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        pwm_cnt_reg <= '0;
      end else if (tick_reg) begin
        // >= so a shortened period wraps at once
        if (pwm_cnt_reg + step_pkg::ONE32 >= pwm_per) begin
          pwm_cnt_reg <= '0;
        end else begin
          pwm_cnt_reg <= pwm_cnt_reg + step_pkg::ONE32;
        end
      end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        pin_reg[c] <= 1'b0;
      end else if (pwm_mode_reg[c]) begin
        if (stop_reg || prm_reg[c].run_rate == '0 ||
            prm_reg[c].start_rate == '0) begin
          pin_reg[c] <= 1'b0;
        end else if (prm_reg[c].start_rate >= step_pkg::DUTY_FULL) begin
          pin_reg[c] <= 1'b1;
        end else begin
          pin_reg[c] <= (pwm_cnt_reg < pwm_high);
        end
      end else begin
        // step high for first half of each cycle, or for the whole cycle when the divider is 1
        pin_reg[c] <= busy_reg[c] && !stop_reg && move_reg[c] &&
                      !wait_tick &&
                      (tcnt_reg[c] < half || div_reg[c] == step_pkg::ONE32);
      end
    end
  end

  // outputs and read port
  logic [31:0] rdata_next;
  always_comb begin
    rdata_next = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      if (addr_i == ch_base[c] + step_pkg::OFF_START_RATE) begin
        rdata_next = prm_reg[c].start_rate;
      end
      if (addr_i == ch_base[c] + step_pkg::OFF_RUN_RATE) begin
        rdata_next = prm_reg[c].run_rate;
      end
      if (addr_i == ch_base[c] + step_pkg::OFF_ACCEL_CNT) begin
        rdata_next = prm_reg[c].accel_cnt;
      end
      if (addr_i == ch_base[c] + step_pkg::OFF_RUN_CNT) begin
        rdata_next = prm_reg[c].run_cnt;
      end
      if (addr_i == ch_base[c] + step_pkg::OFF_DECEL_CNT) begin
        rdata_next = prm_reg[c].decel_cnt;
      end
      if (addr_i == ch_base[c] + step_pkg::OFF_CONTROL) begin
        rdata_next[step_pkg::CTL_MOVE_BIT] = move_reg[c];
        rdata_next[step_pkg::CTL_PWM_BIT]  = pwm_mode_reg[c];
      end
      if (addr_i == ch_base[c] + step_pkg::OFF_STATUS) begin
        rdata_next[step_pkg::STS_IDLE_BIT]  = !busy_reg[c];
        rdata_next[step_pkg::STS_FAULT_BIT] = fault_reg[c];
        rdata_next[step_pkg::STS_BUSY_BIT]  = busy_reg[c];
        rdata_next[step_pkg::STS_PIN_BIT]   = pin_reg[c];
      end
    end
    if (addr_i == step_pkg::OFF_GLOBAL) begin
      rdata_next[step_pkg::GLB_STOP_BIT] = stop_reg;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o         <= '0;
      step_o          <= '0;
      idle_complete_o <= '0;
      fault_o         <= '0;
    end else begin
      rdata_o         <= rd_i ? rdata_next : 32'h0000_0000;
      step_o          <= pin_reg;
      idle_complete_o <= ~busy_reg;
      fault_o         <= fault_reg;
    end
  end

endmodule : stepper_pulse_profile_generator

/* File: tb/step_profile_sva.sv */
`timescale 1ns/1ps
module step_profile_sva #(
  parameter int NUM_CH = step_pkg::NUM_CH
) (
  input wire logic                        core_clk_i,
  input wire logic                        reset_n_i,
  input wire logic [step_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0]                 wdata_i,
  input wire logic                        wr_i,
  input wire logic                        rd_i,
  input wire logic [31:0]                 rdata_o,
  input wire logic [NUM_CH-1:0]           step_o,
  input wire logic [NUM_CH-1:0]           idle_complete_o,
  input wire logic [NUM_CH-1:0]           fault_o
);
  logic req_reg;
  logic pwm_reg;
  logic stop_reg;
  logic freq_nz_reg;
  logic duty_zero_reg;
  logic duty_full_reg;
  logic go_wr;
  // only channel 0 is shadowed, channel 1 is judged by the bench
  assign go_wr = wr_i && addr_i == step_pkg::OFF_CONTROL &&
    wdata_i[step_pkg::CTL_MOVE_BIT] && !wdata_i[step_pkg::CTL_PWM_BIT];
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_reg       <= 1'b0;
      pwm_reg       <= 1'b0;
      stop_reg      <= 1'b0;
      freq_nz_reg   <= 1'b0;
      duty_zero_reg <= 1'b1;
      duty_full_reg <= 1'b0;
    end else if (wr_i) begin
      if (addr_i == step_pkg::OFF_CONTROL) begin
        req_reg <= wdata_i[step_pkg::CTL_MOVE_BIT];
        pwm_reg <= wdata_i[step_pkg::CTL_PWM_BIT];
      end
      if (addr_i == step_pkg::OFF_GLOBAL) begin
        stop_reg <= wdata_i[step_pkg::GLB_STOP_BIT];
      end
      if (addr_i == step_pkg::OFF_RUN_RATE) begin
        freq_nz_reg <= wdata_i != step_pkg::ZERO32;
      end
      if (addr_i == step_pkg::OFF_START_RATE) begin
        duty_zero_reg <= wdata_i == step_pkg::ZERO32;
        duty_full_reg <= wdata_i >= step_pkg::DUTY_FULL;
      end
    end
  end
  a_start_idle_fall: assert property (
    $fell(idle_complete_o[0]) |-> $past(go_wr, 3))
    else $error("ready dropped without a start write");
  a_fault_clear_start: assert property (
    $fell(fault_o[0]) |-> $past(go_wr, 3))
    else $error("fault cleared without a start write");
  a_abort_sets_fault: assert property (
    $fell(req_reg) && !idle_complete_o[0] && !stop_reg |-> ##[1:4] fault_o[0])
    else $error("early request drop left fault low");
  a_stop_pin_low: assert property (
    (stop_reg && !pwm_reg) [*4] |-> !step_o[0])
    else $error("pin high in stop mode");
  a_stop_ready: assert property (
    (stop_reg && !pwm_reg) [*4] |-> idle_complete_o[0])
    else $error("ready low in stop mode");
  a_pwm_full_high: assert property (
    (pwm_reg && duty_full_reg && freq_nz_reg && !stop_reg) [*4] |-> step_o[0])
    else $error("full duty pwm not high");
  a_pwm_zero_low: assert property (
    (pwm_reg && duty_zero_reg) [*4] |-> !step_o[0])
    else $error("zero duty pwm not low");
  a_pwm_wait_low: assert property (
    (pwm_reg && !freq_nz_reg) [*4] |-> !step_o[0])
    else $error("pwm high with zero frequency");
  a_idle_pin_quiet: assert property (
    (!pwm_reg) [*4] ##0 idle_complete_o[0] |-> !step_o[0])
    else $error("step pulse while ready");
  c_move: cover property ($fell(idle_complete_o[0]));
  c_fault: cover property ($rose(fault_o[0]));
  c_pwm_full: cover property (pwm_reg && duty_full_reg && step_o[0]);
endmodule : step_profile_sva

bind stepper_pulse_profile_generator step_profile_sva #(
  .NUM_CH(NUM_CH)
) i_step_profile_sva (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .step_o(step_o), .idle_complete_o(idle_complete_o), .fault_o(fault_o)
);

/* File: tb/step_drive_model.sv */
`timescale 1ns/1ps
module step_drive_model (
  input  wire logic       core_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [1:0] step_i,
  output logic      [1:0] fall_o,
  output logic [1:0][31:0] high_o
);
  logic [1:0]       last_reg;
  logic [1:0][31:0] cnt_reg;
  // a drive input only sees edges, so high time is all it can report
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_reg <= 2'h0;
      cnt_reg  <= '0;
      fall_o   <= 2'h0;
      high_o   <= '0;
    end else begin
      last_reg <= step_i;
      for (int c = 0; c < 2; c++) begin
        fall_o[c]  <= last_reg[c] & ~step_i[c];
        cnt_reg[c] <= step_i[c] ? cnt_reg[c] + 32'h1 : 32'h0;
        if (last_reg[c] & ~step_i[c]) begin
          high_o[c] <= cnt_reg[c];
        end
      end
    end
  end
endmodule : step_drive_model

/* File: tb/stepper_pulse_profile_generator_tb.sv */
`timescale 1ns/1ps
module stepper_pulse_profile_generator_tb;
  logic             core_clk = 1'b0;
  logic             reset_n  = 1'b0;
  logic [7:0]       addr     = 8'h00;
  logic [31:0]      wdata    = 32'h0;
  logic             wr       = 1'b0;
  logic             rd       = 1'b0;
  logic             rd_d     = 1'b0;
  logic             ign      = 1'b0;
  logic [31:0]      rdata;
  logic [1:0]       step;
  logic [1:0]       idle;
  logic [1:0]       fault;
  logic [1:0]       fall;
  logic [1:0][31:0] high;
  int unsigned      miscompares = 0;
  int unsigned      comparisons = 0;
  logic [31:0]      rd_q[$];
  logic [31:0]      hi_q[2][$];
  always #5 core_clk = ~core_clk;
  stepper_pulse_profile_generator i_stepper_pulse_profile_generator (
    .core_clk_i(core_clk), .reset_n_i(reset_n), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .step_o(step), .idle_complete_o(idle), .fault_o(fault));
  step_drive_model i_step_drive_model (.core_clk_i(core_clk),
    .reset_n_i(reset_n), .step_i(step), .fall_o(fall), .high_o(high));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic test_done;
    if (miscompares == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    rd_q.push_back(e);
    @(posedge core_clk);
    rd <= 1'b0;
  endtask : rd_reg
  task automatic load(input int ch, input logic [31:0] s, r, a, n, d);
    logic [7:0] b;
    b = 8'(ch) * step_pkg::CH_STRIDE;
    wr_reg(b + step_pkg::OFF_START_RATE, s);
    wr_reg(b + step_pkg::OFF_RUN_RATE, r);
    wr_reg(b + step_pkg::OFF_ACCEL_CNT, a);
    wr_reg(b + step_pkg::OFF_RUN_CNT, n);
    wr_reg(b + step_pkg::OFF_DECEL_CNT, d);
  endtask : load
  task automatic go(input int ch, input logic [31:0] c);
    wr_reg(8'(ch) * step_pkg::CH_STRIDE + step_pkg::OFF_CONTROL, c);
  endtask : go
  // high time is half the divided period, in core cycles
  function automatic logic [31:0] hi_cyc(input longint rate);
    // whole ticks only: an odd period loses its spare tick
    return 32'(longint'(step_pkg::TB_DIV) *
               (step_pkg::TIMEBASE_HZ / rate / 2));
  endfunction : hi_cyc
  task automatic plan(input int ch, input longint s, r, a, n, d);
    for (longint i = 0; i < a; i++) begin
      hi_q[ch].push_back(hi_cyc(s + (r - s) * i / (a - 1)));
    end
    for (longint i = 0; i < n; i++) begin
      hi_q[ch].push_back(hi_cyc(r));
    end
    for (longint i = 0; i < d; i++) begin
      hi_q[ch].push_back(hi_cyc(r - (r - s) * i / (d - 1)));
    end
  endtask : plan
  task automatic wait_idle(input int ch);
    int k = 0;
    while (idle[ch] !== 1'b1 && k < 30000) begin
      @(posedge core_clk);
      k++;
    end
    chk("ready after move", 32'(idle[ch]), 32'h1);
  endtask : wait_idle
  always @(posedge core_clk) begin
    rd_d <= rd;
    if (rd_d) chk("rdata", rdata, rd_q.pop_front());
    for (int c = 0; c < 2; c++) begin
      if (fall[c] && !ign) begin
        if (hi_q[c].size() == 0) chk("extra pulse", high[c], 32'hFFFF_FFFF);
        else chk("pulse high", high[c], hi_q[c].pop_front());
      end
    end
  end
  initial begin
    cyc(90000);
    miscompares++;
    test_done();
  end
  initial begin
    logic [31:0] s;
    logic [31:0] r;
    logic [31:0] n;
    int          hc;
    void'($urandom(32'hDD720814));
    cyc(5);
    reset_n <= 1'b1;
    cyc(1);
    rd_reg(step_pkg::OFF_STATUS, 32'h1);
    rd_reg(step_pkg::CH_STRIDE + step_pkg::OFF_RUN_CNT, 32'h0);
    rd_reg(8'hFC, 32'h0);
    n = $urandom;
    wr_reg(step_pkg::CH_STRIDE + step_pkg::OFF_ACCEL_CNT, n);
    rd_reg(step_pkg::CH_STRIDE + step_pkg::OFF_ACCEL_CNT, n);
    r = 32'h7_A120 + $urandom_range(32'h7_A120);
    s = 32'h1_86A0 + $urandom_range(r - 32'h1_86A0);
    n = $urandom_range(3);
    load(0, s, r, 32'h3, n, 32'h2);
    load(1, s, r, 32'h0, 32'h2, 32'h0);
    plan(0, s, r, 3, n, 2);
    plan(1, s, r, 0, 2, 0);
    chk("ready before start", 32'(idle), 32'h3);
    go(0, 32'h1);
    go(1, 32'h1);
    // later writes must not touch the latched move
    wr_reg(step_pkg::OFF_RUN_RATE, 32'h3_0D40);
    wr_reg(step_pkg::OFF_ACCEL_CNT, 32'h9);
    chk("busy", 32'(idle), 32'h0);
    wait_idle(0);
    wait_idle(1);
    chk("fault after move", 32'(fault), 32'h0);
    chk("pulses left", hi_q[0].size() + hi_q[1].size(), 32'h0);
    go(0, 32'h0);
    go(1, 32'h0);
    for (int k = 0; k < 5; k++) begin
      case (k)
        0: load(0, s, r, 32'h1, 32'h0, 32'h0);
        1: load(0, s, r, 32'h0, 32'h0, 32'h1);
        2: load(0, 32'h0, r, 32'h2, 32'h0, 32'h0);
        3: load(0, r + 32'h1, r, 32'h0, 32'h0, 32'h2);
        default: load(0, s, 32'h0, 32'h0, 32'h1, 32'h0);
      endcase
      go(0, 32'h1);
      cyc(5);
      chk("bad param fault", 32'(fault[0]), 32'h1);
      chk("bad param ready", 32'(idle[0]), 32'h1);
      go(0, 32'h0);
    end
    load(0, s, r, 32'h0, 32'h0, 32'h0);
    go(0, 32'h1);
    cyc(5);
    chk("fault cleared", 32'(fault[0]), 32'h0);
    chk("empty move ready", 32'(idle[0]), 32'h1);
    go(0, 32'h0);
    // an aborted move has no full pulse list, so stop matching pulses
    ign <= 1'b1;
    load(0, s, r, 32'h2, 32'h5, 32'h2);
    go(0, 32'h1);
    cyc(300);
    go(0, 32'h0);
    cyc(5);
    chk("abort fault", 32'(fault[0]), 32'h1);
    chk("abort ready", 32'(idle[0]), 32'h1);
    go(0, 32'h1);
    cyc(300);
    wr_reg(step_pkg::OFF_GLOBAL, 32'h1);
    cyc(5);
    chk("stop pin", 32'(step[0]), 32'h0);
    chk("stop fault", 32'(fault[0]), 32'h0);
    wr_reg(step_pkg::OFF_GLOBAL, 32'h0);
    go(0, 32'h0);
    wr_reg(step_pkg::OFF_RUN_RATE, 32'h0);
    wr_reg(step_pkg::OFF_START_RATE, 32'h3E80);
    go(0, 32'h2);
    cyc(10);
    chk("pwm no freq", 32'(step[0]), 32'h0);
    wr_reg(step_pkg::OFF_START_RATE, step_pkg::DUTY_FULL);
    wr_reg(step_pkg::OFF_RUN_RATE, 32'h3E8);
    cyc(10);
    chk("pwm full", 32'(step[0]), 32'h1);
    wr_reg(step_pkg::OFF_START_RATE, 32'h0);
    cyc(10);
    chk("pwm zero", 32'(step[0]), 32'h0);
    wr_reg(step_pkg::OFF_START_RATE, 32'h3E80);
    wr_reg(step_pkg::OFF_RUN_RATE, 32'hF_4240);
    cyc(20);
    hc = 0;
    repeat (1000) begin
      @(posedge core_clk);
      hc += int'(step[0] === 1'b1);
    end
    chk("pwm half duty", 32'(hc), 32'h1F4);
    go(0, 32'h0);
    test_done();
  end
endmodule : stepper_pulse_profile_generator_tb
